// ===== dv/pulse_source.sv
`timescale 1ns/1ps

module pulse_source (
   // clock
   input wire logic mclk,
   // pins fed to the timer
   output logic pin_a,
   output logic pin_b
);
   // ------
   // pin drivers
   // ------
   // only this model drives the pins, the timer treats both as inputs
   initial begin
      pin_a = 1'b0;
      pin_b = 1'b0;
   end

   // callers hold each level two samples or more, under one counter cycle, except the glitch pulses held high for one sample
   task automatic set_a(input logic lvl);
      @(posedge mclk);
      pin_a <= lvl;
   endtask

   // same timing duty as set_a
   task automatic set_b(input logic lvl);
      @(posedge mclk);
      pin_b <= lvl;
   endtask
endmodule // pulse_source

// ===== dv/timer_event_counter_capture_tb.sv
`timescale 1ns/1ps
`include "timer_regs.svh"

module timer_event_counter_capture_tb;
   // ------
   // signals
   // ------
   logic mclk = 1'b0;
   logic srst = 1'b1;
   logic ce = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, pin_a, pin_b, match_a_irq, capture_b_irq, overflow_flag;
   int err_total = 0;
   int checks_done = 0;
   int cyc = 0;
   int n_a = 0;
   int n_b = 0;

   // 25 mhz clock
   always #20 mclk = ~mclk;

   // cycle stamp and irq pulse tallies
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (match_a_irq === 1'b1) n_a <= n_a + 1;
      if (capture_b_irq === 1'b1) n_b <= n_b + 1;
   end

   timer_event_counter_capture i_dut (.mclk(mclk), .srst(srst), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .event_input_a(pin_a), .capture_input_b(pin_b),
      .match_a_irq(match_a_irq), .capture_b_irq(capture_b_irq),
      .overflow_flag(overflow_flag));

   pulse_source i_src (.mclk(mclk), .pin_a(pin_a), .pin_b(pin_b));

   // ------
   // common tasks
   // ------
   task automatic conclude();
      $display("counts: %0d checks, %0d mismatches", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // a wait that runs out ends the run
   task automatic timeout();
      err_total++;
      $display("MISMATCH wait expected event seen timeout");
      conclude();
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   // one apb transfer; request held until pready is seen high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      int i;
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge mclk);
         if (pready === 1'b1) break;
      end
      if (i == 50) timeout();
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      apb(1'b1, a, d, q, e);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      logic e;
      apb(1'b0, a, 32'h0, q, e);
   endtask

   // waits for a match pulse or the overflow flag, sampled mid-cycle
   task automatic wait_ev(input bit ovf, input int lim, output int t);
      int i;
      for (i = 0; i < lim; i++) begin
         @(negedge mclk);
         if ((ovf ? overflow_flag : match_a_irq) === 1'b1) break;
      end
      if (i == lim) timeout();
      t = cyc;
   endtask

   // spacing between two match pulses
   task automatic measure(input logic [31:0] exp);
      int t1, t2;
      wait_ev(1'b0, 3000, t1);
      wait_ev(1'b0, 3000, t2);
      chk("match period", exp, 32'(t2 - t1));
   endtask

   task automatic pulse_a();
      i_src.set_a(1'b1);
      repeat (6) @(posedge mclk);
      i_src.set_a(1'b0);
      repeat (10) @(posedge mclk);
   endtask

   task automatic start(input logic [31:0] presc, input logic [31:0] cmp,
                        input logic [31:0] mode);
      wr(`OFS_MODE, 32'h0);
      wr(`OFS_PRESCALE, presc);
      wr(`OFS_CMP_A, cmp);
      wr(`OFS_MODE, mode);
   endtask

   // ------
   // scenarios
   // ------
   task automatic t_regs();
      logic [31:0] q;
      logic e;
      for (int k = 0; k < 7; k++) begin
         rd(8'(k * 4), q);
         chk("reset value", 32'h0, q);
      end
      apb(1'b0, 8'h1c, 32'h0, q, e);
      chk("unmapped error", 32'h1, 32'(e));
      chk("unmapped data", 32'h0, q);
      wr(`OFS_PRESCALE, 32'hff);
      rd(`OFS_PRESCALE, q);
      chk("prescale fields", 32'hf3, q);
      wr(`OFS_COUNT, 32'h1234);
      rd(`OFS_COUNT, q);
      chk("count read only", 32'h0, q);
      $display("test regs finished");
   endtask

   task automatic t_interval();
      logic [31:0] q;
      logic [31:0] cmpv[4] = '{32'h1, 32'h3, 32'h3, 32'h1};
      logic [31:0] selv[4] = '{32'h0, 32'h0, 32'h1, 32'h2};
      logic [31:0] per[4] = '{32'd2, 32'd4, 32'd16, 32'd512};
      for (int k = 0; k < 4; k++) begin
         start(selv[k], cmpv[k], (k == 3) ? 32'h3 : 32'h2);
         measure(per[k]);
      end
      rd(`OFS_STATUS, q);
      chk("no overflow", 32'h0, q);
      $display("test interval finished");
   endtask

   // free-running count must skip exactly the cycles with enable low
   task automatic t_freeze();
      logic [31:0] q1, q2;
      int t1, t2;
      start(32'h0, 32'h0, 32'h1);
      rd(`OFS_COUNT, q1);
      t1 = cyc;
      ce <= 1'b0;
      repeat (20) @(posedge mclk);
      ce <= 1'b1;
      rd(`OFS_COUNT, q2);
      t2 = cyc;
      chk("count frozen by ce", 32'(t2 - t1 - 20), q2 - q1);
      $display("test freeze finished");
   endtask

   task automatic t_edges();
      logic [31:0] q;
      logic [31:0] exp[4] = '{32'h1, 32'h1, 32'h0, 32'h2};
      for (int k = 0; k < 4; k++) begin
         start(32'((k << 4) | 3), 32'hffff, 32'h2);
         repeat (8) @(posedge mclk);
         rd(`OFS_COUNT, q);
         chk("count before edge", 32'h0, q);
         pulse_a();
         rd(`OFS_COUNT, q);
         chk("edge count", exp[k], q);
      end
      $display("test edges finished");
   endtask

   task automatic t_event();
      logic [31:0] q;
      int n0;
      logic [31:0] exp[3] = '{32'h1, 32'h2, 32'h0};
      start(32'h13, 32'h2, 32'h2);
      n0 = n_a;
      for (int k = 0; k < 3; k++) begin
         pulse_a();
         rd(`OFS_COUNT, q);
         chk("event count", exp[k], q);
      end
      chk("match pulses", 32'(n0 + 1), 32'(n_a));
      i_src.set_a(1'b1);
      i_src.set_a(1'b0);
      repeat (10) @(posedge mclk);
      rd(`OFS_COUNT, q);
      chk("glitch ignored", 32'h0, q);
      $display("test event finished");
   endtask

   task automatic t_capture();
      logic [31:0] qa, qb1, qb2;
      int na0, nb0, tb, ta, tf;
      wr(`OFS_CAPCTL, 32'h5);
      start(32'h70, 32'h0, 32'h1);
      repeat (10) @(posedge mclk);
      na0 = n_a;
      nb0 = n_b;
      i_src.set_b(1'b1);
      tb = cyc;
      i_src.set_a(1'b1);
      ta = cyc;
      repeat (12) @(posedge mclk);
      rd(`OFS_CMP_A, qa);
      rd(`OFS_CAP_B, qb1);
      chk("b to a span", 32'(ta - tb), (qb1 - qa) & 32'hffff);
      i_src.set_a(1'b0);
      tf = cyc;
      repeat (12) @(posedge mclk);
      rd(`OFS_CAP_B, qb2);
      chk("pulse width", 32'(tf - ta), (qb2 - qb1) & 32'hffff);
      i_src.set_b(1'b0);
      repeat (12) @(posedge mclk);
      i_src.set_a(1'b1);
      i_src.set_a(1'b0);
      repeat (12) @(posedge mclk);
      chk("match pulses", 32'(na0 + 1), 32'(n_a));
      chk("capture pulses", 32'(nb0 + 2), 32'(n_b));
      wr(`OFS_CAPCTL, 32'h0);
      $display("test capture finished");
   endtask

   task automatic t_detour();
      logic [31:0] q;
      int n0, t;
      start(32'h0, 32'h100, 32'h2);
      repeat (200) @(posedge mclk);
      wr(`OFS_CMP_A, 32'h10);
      n0 = n_a;
      wait_ev(1'b1, 70000, t);
      chk("no match on detour", 32'(n0), 32'(n_a));
      rd(`OFS_COUNT, q);
      chk("count restarted", 32'h1, 32'(q < 32'h20));
      measure(32'h11);
      rd(`OFS_STATUS, q);
      chk("overflow set", 32'h1, q);
      wr(`OFS_STATUS, 32'h1);
      rd(`OFS_STATUS, q);
      chk("overflow cleared", 32'h0, q);
      $display("test detour finished");
   endtask

   // ------
   // main sequence
   // ------
   initial begin
      repeat (12) @(posedge mclk);
      srst <= 1'b0;
      t_regs();
      t_interval();
      t_freeze();
      t_edges();
      t_event();
      t_capture();
      t_detour();
      conclude();
   end
endmodule // timer_event_counter_capture_tb

// ===== hdl/edge_filter.sv
`timescale 1ns/1ps
`include "timer_regs.svh"

module edge_filter (
   // clock and control
   input wire logic mclk,
   input wire logic srst,
   input wire logic ce,
   input wire logic sample,
   // pin and edge choice
   input wire logic pin,
   input wire logic [1:0] sel,
   // filtered edge pulses
   output logic valid,
   output logic inv
);

   timer_pkg::filt_state_type st_r;
   timer_pkg::filt_state_type st_nxt;
   logic lvl;
   logic rise;
   logic fall;

   // ----------------------------------------------------------------
   // sampling and two-sample level check
   // ----------------------------------------------------------------
   // a new level counts only once seen on two samples in a row
   always_comb begin
      st_nxt = st_r;
      st_nxt.sync = {st_r.sync[0], pin};
      lvl = st_r.sync[1];
      rise = 1'b0;
      fall = 1'b0;
      if (sample) begin
         st_nxt.hist = lvl;
         if ((lvl == st_r.hist) && (lvl != st_r.stable)) begin
            st_nxt.stable = lvl;
            rise = lvl;
            fall = !lvl;
         end
      end
      // prohibited code 2'h2 yields no edge at all
      case (sel)
         `SEL_FALL: begin
            st_nxt.valid = fall;
            st_nxt.inv = rise;
         end
         `SEL_RISE: begin
            st_nxt.valid = rise;
            st_nxt.inv = fall;
         end
         `SEL_BOTH: begin
            st_nxt.valid = rise || fall;
            st_nxt.inv = 1'b0;
         end
         default: begin
            st_nxt.valid = 1'b0;
            st_nxt.inv = 1'b0;
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         st_r <= '0;
      end else if (ce) begin
         st_r <= st_nxt;
      end
   end

   assign valid = st_r.valid;
   assign inv = st_r.inv;

   a_edge_twice: assert property (@(posedge mclk) disable iff (srst)
      (st_r.valid || st_r.inv) && $past(ce) |-> $past(st_r.stable) != st_r.stable) // (RULE_09)
      else $error("edge reported without a two-sample level change");

   // the prohibited code must stay silent on both outputs
   a_code_two_quiet: assert property (@(posedge mclk) disable iff (srst)
      ce && sel == 2'h2 |=> !valid && !inv) // (RULE_20)
      else $error("prohibited edge code produced an edge");

endmodule // edge_filter

// ===== hdl/prescaler.sv
`timescale 1ns/1ps
`include "timer_regs.svh"

module prescaler (
   // clock and control
   input wire logic mclk,
   input wire logic srst,
   input wire logic ce,
   // divider selection
   input wire logic [1:0] sel,
   // count clock enable
   output logic tick
);

   logic [7:0] div_r;
   logic [7:0] div_nxt;

   // ----------------------------------------------------------------
   // free-running divider
   // ----------------------------------------------------------------
   // runs continuously, so a slow clock phase is not tied to start
   always_comb begin
      div_nxt = div_r + 8'h01;
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         div_r <= 8'h00;
      end else if (ce) begin
         div_r <= div_nxt;
      end
   end

   // tick selection; event clock samples at full rate
   always_comb begin
      case (sel)
         `CLK_DIV4: tick = ce && (div_r[1:0] == `DIV4_LAST);
         `CLK_DIV256: tick = ce && (div_r == `DIV256_LAST);
         default: tick = ce;
      endcase
   end

endmodule // prescaler

// ===== hdl/timer_event_counter_capture.sv
// What this block does
// (RULE_01) interval is compare value plus one
// (RULE_02) overflow during clear mode only at FFFFH
// (RULE_03) compare below count: wrap, then from zero
// (RULE_04) software restarts after lowering compare value
// (RULE_05) event mode counts each valid pin edge
// (RULE_06) event mode clears on match, raises irq
// (RULE_07) software keeps event compare value nonzero
// (RULE_08) prescale bits 5:4 pick event edges
// (RULE_09) event pin needs two equal samples
// (RULE_10) counting waits for a filtered valid edge
// (RULE_11) event count read from count register
// (RULE_12) capture inputs sampled twice at count clock
// (RULE_13) event edges copy count into capture_b
// (RULE_14) pin b edge copies count, raises match
// (RULE_15) software reads capture, checks, clears overflow
// (RULE_16) software measures at most one counter cycle
// (RULE_17) software writes control, clock, then mode
// (RULE_18) software sets both capture pins as inputs
// (RULE_19) interval match clears counter, raises irq
// (RULE_20) edge codes fall, rise, both; 10 prohibited
// (RULE_21) prescale bits 1:0 choose count clock
// (RULE_22) free-running wraps and sets overflow flag
//
// Chosen here: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`include "timer_regs.svh"

module timer_event_counter_capture (
   // clock and control
   input wire logic mclk,
   input wire logic srst,
   input wire logic ce,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // input pins
   input wire logic event_input_a,
   input wire logic capture_input_b,
   // event outputs
   output logic match_a_irq,
   output logic capture_b_irq,
   output logic overflow_flag
);

   timer_pkg::timer_state_type st_r;
   timer_pkg::timer_state_type st_nxt;
   timer_pkg::run_type run_mode;
   logic presc_tick;
   logic samp_a;
   logic edge_a;
   logic inv_a;
   logic edge_b;
   logic inv_b;
   logic run;
   logic tick;
   logic match;
   logic cap_a;
   logic cap_b;
   logic setup_rd;
   logic wr;
   logic mapped;
   logic [1:0] clk_sel;

   // ----------------------------------------------------------------
   // count clock and input filters
   // ----------------------------------------------------------------
   assign clk_sel = st_r.presc[`CLKSEL_LSB +: 2];

   prescaler u_presc (
      .mclk(mclk),
      .srst(srst),
      .ce(ce),
      .sel(clk_sel), // (RULE_21)
      .tick(presc_tick)
   );

   // event pin used as clock is sampled at full rate, else at count clock
   assign samp_a = (clk_sel == `CLK_EVENT) ? ce : presc_tick; // (RULE_09)

   edge_filter u_filt_a (
      .mclk(mclk),
      .srst(srst),
      .ce(ce),
      .sample(samp_a), // (RULE_12)
      .pin(event_input_a),
      .sel(st_r.presc[`EDGE_A_LSB +: 2]), // (RULE_08)
      .valid(edge_a),
      .inv(inv_a)
   );

   edge_filter u_filt_b (
      .mclk(mclk),
      .srst(srst),
      .ce(ce),
      .sample(presc_tick), // (RULE_12)
      .pin(capture_input_b),
      .sel(st_r.presc[`EDGE_B_LSB +: 2]), // (RULE_20)
      .valid(edge_b),
      .inv(inv_b)
   );

   // ----------------------------------------------------------------
   // mode decode and event conditions
   // ----------------------------------------------------------------
   // both upper mode codes clear on match
   always_comb begin
      case (st_r.mode)
         2'h0: run_mode = timer_pkg::run_stop;
         2'h1: run_mode = timer_pkg::run_free;
         default: run_mode = timer_pkg::run_clear;
      endcase
   end

   assign run = (run_mode != timer_pkg::run_stop);
   // in event mode the count clock is the filtered edge only
   assign tick = run && ((clk_sel == `CLK_EVENT) ? edge_a : presc_tick); // (RULE_05) (RULE_10)
   // a register used for capture never acts as compare
   assign match = tick && (run_mode == timer_pkg::run_clear)
      && !st_r.capctl[`CAPCTL_A_EN] && (st_r.count == st_r.cmp_a); // (RULE_19) (RULE_06)
   assign cap_b = run && st_r.capctl[`CAPCTL_B_EN] && edge_a; // (RULE_13)
   assign cap_a = run && st_r.capctl[`CAPCTL_A_EN]
      && (st_r.capctl[`CAPCTL_A_INV] ? inv_a : edge_b); // (RULE_14)

   // ----------------------------------------------------------------
   // apb decode
   // ----------------------------------------------------------------
   always_comb begin
      case (paddr)
         `OFS_COUNT, `OFS_CMP_A, `OFS_CAP_B, `OFS_PRESCALE,
         `OFS_CAPCTL, `OFS_MODE, `OFS_STATUS: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end

   // zero wait states; read data is fetched during the setup cycle
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;
   assign setup_rd = ce && psel && !penable && !pwrite;
   assign wr = ce && psel && penable && pwrite && mapped;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      st_nxt = st_r;
      st_nxt.match_irq = 1'b0;
      st_nxt.capb_irq = 1'b0;

      // software writes; count and capture_b are read only
      if (wr) begin
         case (paddr)
            `OFS_CMP_A: st_nxt.cmp_a = pwdata[15:0];
            `OFS_PRESCALE: st_nxt.presc = {pwdata[7:4], 2'h0, pwdata[1:0]};
            `OFS_CAPCTL: st_nxt.capctl = pwdata[2:0];
            `OFS_MODE: st_nxt.mode = pwdata[1:0];
            `OFS_STATUS: begin
               if (pwdata[`STATUS_OVF]) begin
                  st_nxt.ovf = 1'b0;
               end
            end
            default: st_nxt.ovf = st_nxt.ovf;
         endcase
      end

      // counter; stopping clears it so a restart begins at zero
      if (!run) begin
         st_nxt.count = `RST_COUNT;
      end else if (tick) begin
         if (st_r.count == `COUNT_TOP) begin
            st_nxt.ovf = 1'b1; // (RULE_22) (RULE_02)
         end
         if (match) begin
            st_nxt.count = `RST_COUNT; // (RULE_01) (RULE_19) (RULE_06)
            st_nxt.match_irq = 1'b1;
         end else begin
            // passes a lowered compare value and wraps (RULE_03)
            st_nxt.count = st_r.count + 16'h0001;
         end
      end

      // captures win over a software write in the same cycle
      if (cap_b) begin
         st_nxt.cap_b = st_r.count; // (RULE_13)
         st_nxt.capb_irq = 1'b1;
      end
      if (cap_a) begin
         st_nxt.cmp_a = st_r.count; // (RULE_14)
         st_nxt.match_irq = 1'b1;
      end

      // read data
      if (setup_rd) begin
         case (paddr)
            `OFS_COUNT: st_nxt.prdata = {16'h0000, st_r.count}; // (RULE_11)
            `OFS_CMP_A: st_nxt.prdata = {16'h0000, st_r.cmp_a};
            `OFS_CAP_B: st_nxt.prdata = {16'h0000, st_r.cap_b};
            `OFS_PRESCALE: st_nxt.prdata = {24'h000000, st_r.presc};
            `OFS_CAPCTL: st_nxt.prdata = {29'h00000000, st_r.capctl};
            `OFS_MODE: st_nxt.prdata = {30'h00000000, st_r.mode};
            `OFS_STATUS: st_nxt.prdata = {31'h00000000, st_r.ovf};
            default: st_nxt.prdata = 32'h00000000;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (srst) begin
         st_r <= '0;
         st_r.presc <= `RST_PRESCALE;
         st_r.capctl <= `RST_CAPCTL;
         st_r.mode <= `RST_MODE;
         st_r.cmp_a <= `RST_CMP;
      end else if (ce) begin
         st_r <= st_nxt;
      end
   end

   assign prdata = st_r.prdata;
   assign match_a_irq = st_r.match_irq;
   assign capture_b_irq = st_r.capb_irq;
   assign overflow_flag = st_r.ovf;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   a_match_clear: assert property (@(posedge mclk) disable iff (srst)
      ce && match && !wr |=> st_r.count == 16'h0000 && st_r.match_irq) // (RULE_19)
      else $error("compare match did not clear counter and raise irq");

   a_count_step: assert property (@(posedge mclk) disable iff (srst)
      ce && tick && !match && !wr |=> st_r.count == $past(st_r.count) + 16'h0001) // (RULE_03)
      else $error("counter did not advance by one on count clock");

   a_event_hold: assert property (@(posedge mclk) disable iff (srst)
      ce && run && clk_sel == `CLK_EVENT && !edge_a && !wr
      |=> st_r.count == $past(st_r.count)) // (RULE_05)
      else $error("event counter moved without a valid edge");

   a_ovf_top: assert property (@(posedge mclk) disable iff (srst)
      $rose(st_r.ovf) |-> $past(st_r.count) == 16'hffff && $past(tick)) // (RULE_02)
      else $error("overflow set away from counter top");

   a_ovf_wrap: assert property (@(posedge mclk) disable iff (srst)
      ce && tick && st_r.count == 16'hffff |=> st_r.ovf && st_r.count == 16'h0000) // (RULE_22)
      else $error("wrap did not set overflow or return to zero");

   a_capb_copy: assert property (@(posedge mclk) disable iff (srst)
      ce && cap_b |=> st_r.cap_b == $past(st_r.count) && st_r.capb_irq) // (RULE_13)
      else $error("capture_b did not take the count");

   a_capa_copy: assert property (@(posedge mclk) disable iff (srst)
      ce && cap_a |=> st_r.cmp_a == $past(st_r.count) && st_r.match_irq) // (RULE_14)
      else $error("compare_capture_a did not take the count");

   a_count_read: assert property (@(posedge mclk) disable iff (srst)
      setup_rd && paddr == `OFS_COUNT
      |=> prdata == {16'h0000, $past(st_r.count)}) // (RULE_11)
      else $error("count read returned wrong value");

   a_stop_zero: assert property (@(posedge mclk) disable iff (srst)
      ce && !run |=> st_r.count == 16'h0000 [*1]) // (RULE_10)
      else $error("stopped counter not held at zero");

   // ----------------------------------------------------------------
   // flag, irq, freeze and register checks
   // ----------------------------------------------------------------
   // a low enable must leave every register, irq pulses included, untouched
   a_freeze_hold: assert property (@(posedge mclk) disable iff (srst)
      !ce |=> st_r == $past(st_r))
      else $error("state moved while clock enable was low");

   // overflow is sticky: only a status write of one may drop it
   a_ovf_sticky: assert property (@(posedge mclk) disable iff (srst)
      st_r.ovf && !(wr && paddr == `OFS_STATUS && pwdata[`STATUS_OVF])
      |=> st_r.ovf) // (RULE_22)
      else $error("overflow flag dropped without a clear");

   // a clear loses only to a wrap in the same cycle
   a_ovf_clear: assert property (@(posedge mclk) disable iff (srst)
      wr && paddr == `OFS_STATUS && pwdata[`STATUS_OVF]
      && !(tick && st_r.count == 16'hffff)
      |=> !st_r.ovf) // (RULE_22)
      else $error("overflow flag not cleared by software");

   // every match pulse has a cause one cycle earlier
   a_irq_cause: assert property (@(posedge mclk) disable iff (srst)
      st_r.match_irq && $past(ce) |-> $past(match || cap_a)) // (RULE_19)
      else $error("match irq without match or capture");

   a_capb_cause: assert property (@(posedge mclk) disable iff (srst)
      st_r.capb_irq && $past(ce) |-> $past(cap_b)) // (RULE_13)
      else $error("capture_b irq without a capture");

   // capture_b is read only: nothing but a capture may change it
   a_capb_hold: assert property (@(posedge mclk) disable iff (srst)
      ce && !cap_b |=> st_r.cap_b == $past(st_r.cap_b)) // (RULE_13)
      else $error("capture_b changed without a capture");

   // a software write lands unless a capture takes the register
   a_cmp_write: assert property (@(posedge mclk) disable iff (srst)
      wr && paddr == `OFS_CMP_A && !cap_a
      |=> st_r.cmp_a == $past(pwdata[15:0])) // (RULE_01)
      else $error("compare value write did not land");

endmodule // timer_event_counter_capture

// ===== hdl/timer_pkg.sv
package timer_pkg;

   // ----------------------------------------------------------------
   // counter run modes decoded from the mode register
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {run_stop, run_free, run_clear} run_type;

   // ----------------------------------------------------------------
   // state of one input filter
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [1:0] sync;
      logic hist;
      logic stable;
      logic valid;
      logic inv;
   } filt_state_type;

   // ----------------------------------------------------------------
   // state of the timer core
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [15:0] count;
      logic [15:0] cmp_a;
      logic [15:0] cap_b;
      logic [7:0] presc;
      logic [2:0] capctl;
      logic [1:0] mode;
      logic ovf;
      logic match_irq;
      logic capb_irq;
      logic [31:0] prdata;
   } timer_state_type;

endpackage

// ===== hdl/timer_regs.svh
`ifndef TIMER_REGS_SVH
`define TIMER_REGS_SVH

// ----------------------------------------------------------------
// register byte offsets on the apb bus
// ----------------------------------------------------------------
`define OFS_COUNT 8'h00
`define OFS_CMP_A 8'h04
`define OFS_CAP_B 8'h08
`define OFS_PRESCALE 8'h0c
`define OFS_CAPCTL 8'h10
`define OFS_MODE 8'h14
`define OFS_STATUS 8'h18

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CLKSEL_LSB 0
`define EDGE_A_LSB 4
`define EDGE_B_LSB 6
`define CAPCTL_A_EN 0
`define CAPCTL_A_INV 1
`define CAPCTL_B_EN 2
`define STATUS_OVF 0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_PRESCALE 8'h00
`define RST_CAPCTL 3'h0
`define RST_MODE 2'h0
`define RST_COUNT 16'h0000
`define RST_CMP 16'h0000

// ----------------------------------------------------------------
// encodings and timing counts
// ----------------------------------------------------------------
`define SEL_FALL 2'h0
`define SEL_RISE 2'h1
`define SEL_BOTH 2'h3
`define CLK_DIV1 2'h0
`define CLK_DIV4 2'h1
`define CLK_DIV256 2'h2
`define CLK_EVENT 2'h3
`define DIV4_LAST 8'h03
`define DIV256_LAST 8'hff
`define COUNT_TOP 16'hffff

`endif
